/* File: pkg/pnc_pkg.sv */
package pnc_pkg;
  // ===========================================================
  // command codes
  localparam logic [7:0] CMD_WORD_PROG   = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG    = 8'he8;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
  localparam logic [7:0] CMD_LOCK        = 8'h01;
  localparam logic [7:0] CMD_UNLOCK      = 8'hd0;
  localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
  localparam logic [7:0] CMD_PW_SETUP    = 8'h90;

  // ===========================================================
  // geometry
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 8;
  localparam int BLK_W   = 2;
  localparam int NUM_BLK = 4;
  localparam int WORDS   = 256;
  localparam int BUF_CNT_W = 4;

  // ===========================================================
  // status bit positions
  localparam int SR_READY     = 7;
  localparam int SR_ERS_SUSP  = 6;
  localparam int SR_ERS_ERR   = 5;
  localparam int SR_PRG_ERR   = 4;
  localparam int SR_SUPPLY    = 3;
  localparam int SR_PRG_SUSP  = 2;
  localparam int SR_LOCK_ERR  = 1;
  localparam logic [DATA_W-1:0] SR_RESET = 16'h0080;

  // configuration bit that selects burst reads; 1 = async page
  localparam int  CFG_SYNC_BIT = 15;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h8000;

  // ===========================================================
  // timing
  localparam int CLK_MHZ       = 50;
  localparam int PROG_TIME_US  = 1;
  localparam int ERASE_TIME_US = 4;
  localparam int PROG_CYC  = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int BURST_LAT = 2;

  typedef enum logic [2:0] {
    PNC_IDLE, PNC_PROG, PNC_ERASE, PNC_BUFLOAD, PNC_BUFRUN
  } pnc_op_e;
endpackage : pnc_pkg

/* File: design/pnc_burst.sv */
`timescale 1ns/1ps
// burst read port on the host clock domain
module pnc_burst (
  input  wire logic                         link_clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         sync_mode_i,
  input  wire logic                         adv_n_i,
  input  wire logic                         ce_n_i,
  input  wire logic [pnc_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [pnc_pkg::DATA_W-1:0]   mem_rd_i,
  output logic      [pnc_pkg::ADDR_W-1:0]   mem_addr_o,
  output logic      [pnc_pkg::DATA_W-1:0]   burst_data_o,
  output logic                              wait_o
);
  logic [1:0]                 mode_sync_q;
  logic [1:0]                 lat_q;
  logic [pnc_pkg::ADDR_W-1:0] baddr_q;

  // ===========================================================
  // mode crossing: level, two flops
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) mode_sync_q <= 2'h0;
    else           mode_sync_q <= {mode_sync_q[0], sync_mode_i};
  end

  // address latch and latency count; wait high while data not valid
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat_q   <= 2'h0;
      baddr_q <= '0;
    end else if (ce_n_i || !mode_sync_q[1]) begin
      lat_q   <= 2'h0;
    end else if (!adv_n_i) begin
      baddr_q <= addr_i;
      lat_q   <= 2'(pnc_pkg::BURST_LAT);
    end else if (lat_q != 2'h0) begin
      lat_q   <= lat_q - 2'h1;
    end else begin
      baddr_q <= baddr_q + 8'h01;
    end
  end

  // data word per host clock edge
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_data_o <= '0;
      wait_o       <= 1'b0;
    end else begin
      burst_data_o <= mem_rd_i;
      wait_o       <= mode_sync_q[1] && !ce_n_i && (lat_q != 2'h0 || !adv_n_i);
    end
  end

  assign mem_addr_o = baddr_q;

  a_wait_latency: assert property (@(posedge link_clk_i)
    disable iff (!resetn_i)
    (mode_sync_q[1] && !ce_n_i && !adv_n_i) |=> wait_o)
    else $error("wait not raised after address");
  a_async_no_wait: assert property (@(posedge link_clk_i)
    disable iff (!resetn_i)
    !mode_sync_q[1] |=> !wait_o)
    else $error("wait in async mode");
  c_burst: cover property (@(posedge link_clk_i) disable iff (!resetn_i)
    wait_o ##1 !wait_o);
endmodule : pnc_burst

/* File: design/pnc_core.sv */
`timescale 1ns/1ps
module pnc_core (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       link_clk_i,
  input  wire logic                       ce_n_i,
  input  wire logic                       we_n_i,
  input  wire logic                       oe_n_i,
  input  wire logic                       adv_n_i,
  input  wire logic [pnc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pnc_pkg::DATA_W-1:0] data_i,
  input  wire logic                       supply_ok_i,
  input  wire logic                       pw_match_i,
  output logic      [pnc_pkg::DATA_W-1:0] data_o,
  output logic                            data_oe_o,
  output logic      [pnc_pkg::DATA_W-1:0] burst_data_o,
  output logic                            wait_o,
  output logic                            sync_mode_o,
  output logic                            ready_o
);
  localparam int DW = pnc_pkg::DATA_W;
  localparam int AW = pnc_pkg::ADDR_W;

  // ===========================================================
  // pin synchronisers
  logic [1:0]    ce_s_q, we_s_q, oe_s_q, sup_s_q, pw_s_q;
  logic          strobe_q;
  logic [AW-1:0] addr_s1_q, addr_s2_q;
  logic [DW-1:0] data_s1_q, data_s2_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ce_s_q  <= 2'h3;
      we_s_q  <= 2'h3;
      oe_s_q  <= 2'h3;
      sup_s_q <= 2'h0;
      pw_s_q  <= 2'h0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      ce_s_q  <= {ce_s_q[0], ce_n_i};
      we_s_q  <= {we_s_q[0], we_n_i};
      oe_s_q  <= {oe_s_q[0], oe_n_i};
      sup_s_q <= {sup_s_q[0], supply_ok_i};
      pw_s_q  <= {pw_s_q[0], pw_match_i};
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= data_i;
      data_s2_q <= data_s1_q;
    end
  end

  // write active while both low; capture at whichever rises first
  logic strobe_now, wr_evt;
  assign strobe_now = !ce_s_q[1] && !we_s_q[1];
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) strobe_q <= 1'b0;
    else           strobe_q <= strobe_now;
  end
  assign wr_evt = strobe_q && !strobe_now;

  // latched write, taken one cycle before release (stable by then)
  logic [AW-1:0] waddr_q;
  logic [DW-1:0] wdata_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waddr_q <= '0;
      wdata_q <= '0;
    end else if (strobe_now) begin
      waddr_q <= addr_s2_q;
      wdata_q <= data_s2_q;
    end
  end

  function automatic logic [pnc_pkg::BLK_W-1:0] blk_of(
    input logic [AW-1:0] a);
    blk_of = a[AW-1 -: pnc_pkg::BLK_W];
  endfunction : blk_of

  // ===========================================================
  // array and protection state
  logic [DW-1:0] mem_q [pnc_pkg::WORDS];
  logic [pnc_pkg::NUM_BLK-1:0] locked_q, pw_prot_q;
  logic [DW-1:0] status_q, cfg_q;
  pnc_pkg::pnc_op_e op_q;
  logic [7:0]    pend_q;
  logic          stat_mode_q, susp_q;
  logic [AW-1:0] op_addr_q;
  logic [DW-1:0] op_data_q;
  logic [15:0]   timer_q;
  logic [pnc_pkg::BLK_W-1:0] bufcnt_q;
  logic [DW-1:0] buf_q [4];
  logic [AW-1:0] buf_addr_q;

  logic busy, writable, done, cmd_ok_blk;
  assign busy     = (op_q != pnc_pkg::PNC_IDLE) && (op_q != pnc_pkg::PNC_BUFLOAD);
  assign writable = sup_s_q[1];
  assign done     = busy && !susp_q && (timer_q == 16'h0001);
  assign cmd_ok_blk = !locked_q[blk_of(waddr_q)] &&
                      !(pw_prot_q[blk_of(waddr_q)] && !pw_s_q[1]);
  logic susp_blk_ok;
  // suspended erase forbids reads of its own block only
  assign susp_blk_ok = !susp_q || (op_q != pnc_pkg::PNC_ERASE) ||
                       (blk_of(addr_s2_q) != blk_of(op_addr_q));

  // command decoder and operation sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_q        <= pnc_pkg::PNC_IDLE;
      pend_q      <= pnc_pkg::CMD_READ_ARRAY;
      stat_mode_q <= 1'b0;
      susp_q      <= 1'b0;
      op_addr_q   <= '0;
      op_data_q   <= '0;
      timer_q     <= '0;
      bufcnt_q    <= '0;
      buf_addr_q  <= '0;
      status_q    <= pnc_pkg::SR_RESET;
      cfg_q       <= pnc_pkg::CFG_RESET;
      locked_q    <= '0;
      pw_prot_q   <= '0;
    end else begin
      if (busy && !susp_q && timer_q != 16'h0000) timer_q <= timer_q - 16'h1;
      if (done) begin // self-timed finish
        op_q <= pnc_pkg::PNC_IDLE;
        status_q[pnc_pkg::SR_READY] <= 1'b1;
      end
      if (wr_evt) begin
        pend_q <= wdata_q[7:0];
        if (busy && !susp_q) begin
          // only status and suspend while running
          if (wdata_q[7:0] == pnc_pkg::CMD_SUSPEND) begin
            susp_q <= 1'b1;
            status_q[pnc_pkg::SR_READY] <= 1'b1;
            if (op_q == pnc_pkg::PNC_ERASE)
              status_q[pnc_pkg::SR_ERS_SUSP] <= 1'b1;
            else
              status_q[pnc_pkg::SR_PRG_SUSP] <= 1'b1;
          end
          stat_mode_q <= 1'b1;
        end else if (pend_q == pnc_pkg::CMD_WORD_PROG && !busy) begin
          // address and data cycle after 40h
          stat_mode_q <= 1'b1;
          if (!writable || !cmd_ok_blk) begin
            status_q[pnc_pkg::SR_PRG_ERR] <= 1'b1;
            status_q[pnc_pkg::SR_SUPPLY]  <= !writable;
            status_q[pnc_pkg::SR_LOCK_ERR] <= !cmd_ok_blk;
          end else begin
            op_q      <= pnc_pkg::PNC_PROG;
            op_addr_q <= waddr_q;
            op_data_q <= wdata_q;
            timer_q   <= 16'(pnc_pkg::PROG_CYC);
            status_q[pnc_pkg::SR_READY] <= 1'b0;
          end
        end else if (pend_q == pnc_pkg::CMD_BUF_PROG) begin
          // count cycle after E8h opens buffer load
          op_q       <= pnc_pkg::PNC_BUFLOAD;
          bufcnt_q   <= '0;
          buf_addr_q <= waddr_q;
          pend_q     <= 8'h00;
        end else if (op_q == pnc_pkg::PNC_BUFLOAD) begin
          if (wdata_q[7:0] == pnc_pkg::CMD_CONFIRM && bufcnt_q == 2'h0
              && pend_q == 8'h0f) begin
            stat_mode_q <= 1'b1;
            if (!writable || !cmd_ok_blk) begin
              op_q <= pnc_pkg::PNC_IDLE;
              status_q[pnc_pkg::SR_PRG_ERR] <= 1'b1;
              status_q[pnc_pkg::SR_SUPPLY]  <= !writable;
            end else begin
              op_q    <= pnc_pkg::PNC_BUFRUN;
              op_addr_q <= buf_addr_q;
              timer_q <= 16'(pnc_pkg::PROG_CYC);
              status_q[pnc_pkg::SR_READY] <= 1'b0;
            end
          end else begin
            bufcnt_q <= bufcnt_q + 2'h1;
            pend_q   <= (bufcnt_q == 2'h3) ? 8'h0f : 8'h00;
          end
        end else if (pend_q == pnc_pkg::CMD_ERASE_SETUP && !busy) begin
          stat_mode_q <= 1'b1;
          if (wdata_q[7:0] == pnc_pkg::CMD_CONFIRM) begin
            if (!writable || !cmd_ok_blk) begin
              status_q[pnc_pkg::SR_ERS_ERR] <= 1'b1;
              status_q[pnc_pkg::SR_SUPPLY]  <= !writable;
            end else begin
              op_q      <= pnc_pkg::PNC_ERASE; // one block
              op_addr_q <= waddr_q;
              timer_q   <= 16'(pnc_pkg::ERASE_CYC);
              status_q[pnc_pkg::SR_READY] <= 1'b0;
            end
          end
        end else if (pend_q == pnc_pkg::CMD_LOCK_SETUP) begin
          // lock state changes on this write
          if (wdata_q[7:0] == pnc_pkg::CMD_LOCK)
            locked_q[blk_of(waddr_q)] <= 1'b1;
          else if (wdata_q[7:0] == pnc_pkg::CMD_UNLOCK)
            locked_q[blk_of(waddr_q)] <= 1'b0;
          else if (wdata_q[7:0] == pnc_pkg::CMD_CFG_CONFIRM)
            cfg_q <= {waddr_q, waddr_q};
        end else if (pend_q == pnc_pkg::CMD_PW_SETUP) begin
          // designate password-protected block when password ok
          if (pw_s_q[1]) pw_prot_q[blk_of(waddr_q)] <= wdata_q[0];
        end else begin
          unique case (wdata_q[7:0])
            pnc_pkg::CMD_READ_STATUS: stat_mode_q <= 1'b1;
            pnc_pkg::CMD_READ_ARRAY:  stat_mode_q <= 1'b0;
            pnc_pkg::CMD_CLR_STATUS:
              status_q <= {status_q[DW-1:6], 6'h00};
            pnc_pkg::CMD_CONFIRM: if (susp_q) begin // resume
              susp_q <= 1'b0;
              status_q[pnc_pkg::SR_READY]    <= 1'b0;
              status_q[pnc_pkg::SR_ERS_SUSP] <= 1'b0;
              status_q[pnc_pkg::SR_PRG_SUSP] <= 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // array update: program clears bits, erase sets the block to ones
  always_ff @(posedge clk_i) begin
    if (wr_evt && op_q == pnc_pkg::PNC_BUFLOAD && pend_q != 8'h0f)
      buf_q[bufcnt_q] <= wdata_q;
  end
  // one process per word, so each word has a single driver
  genvar gi;
  for (gi = 0; gi < pnc_pkg::WORDS; gi++) begin : g_word
    localparam logic [AW-1:0] IDX = AW'(gi);
    always_ff @(posedge clk_i) begin
      if (done && op_q == pnc_pkg::PNC_ERASE &&
          blk_of(IDX) == blk_of(op_addr_q))
        mem_q[gi] <= '1;
      else if (done && op_q == pnc_pkg::PNC_BUFRUN &&
               IDX[AW-1:2] == buf_addr_q[AW-1:2])
        mem_q[gi] <= mem_q[gi] & buf_q[gi % 4];
      else if (done && op_q == pnc_pkg::PNC_PROG && IDX == op_addr_q)
        mem_q[gi] <= mem_q[gi] & op_data_q;
    end
  end

  // ===========================================================
  // async read path; reads blocked while running, where a suspended word program or erase alters, and in password blocks without pw_match_i
  logic rd_ok;
  assign rd_ok = !(pw_prot_q[blk_of(addr_s2_q)] && !pw_s_q[1]) &&
    !(busy && !susp_q) && !(susp_q && op_q == pnc_pkg::PNC_PROG &&
    addr_s2_q == op_addr_q) && susp_blk_ok;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o    <= '0;
      data_oe_o <= 1'b0;
      ready_o   <= 1'b1;
      sync_mode_o <= 1'b0;
    end else begin
      data_oe_o <= !ce_s_q[1] && !oe_s_q[1];
      data_o    <= (stat_mode_q || (busy && !susp_q)) ? status_q :
                   rd_ok ? mem_q[addr_s2_q] : '1;
      ready_o   <= status_q[pnc_pkg::SR_READY];
      sync_mode_o <= !cfg_q[pnc_pkg::CFG_SYNC_BIT];
    end
  end

  logic [AW-1:0] b_addr;
  pnc_burst u_burst (
    .link_clk_i   (link_clk_i),
    .resetn_i     (resetn_i),
    .sync_mode_i  (sync_mode_o),
    .adv_n_i      (adv_n_i),
    .ce_n_i       (ce_n_i),
    .addr_i       (addr_i),
    .mem_rd_i     (mem_q[b_addr]),
    .mem_addr_o   (b_addr),
    .burst_data_o (burst_data_o),
    .wait_o       (wait_o)
  );

  // ===========================================================
  // checks
  a_lockout_refuse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_evt && !writable && pend_q == pnc_pkg::CMD_WORD_PROG && !busy)
    |=> op_q == pnc_pkg::PNC_IDLE)
    else $error("program accepted under supply lockout");
  a_prog_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_evt && writable && cmd_ok_blk && !busy &&
     pend_q == pnc_pkg::CMD_WORD_PROG) |=> op_q == pnc_pkg::PNC_PROG)
    else $error("word program not started");
  a_busy_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (busy && !susp_q) |-> !status_q[pnc_pkg::SR_READY])
    else $error("ready set while running");
  a_done_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done |=> status_q[pnc_pkg::SR_READY] && op_q == pnc_pkg::PNC_IDLE)
    else $error("operation did not finish");
  a_busy_ignore: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (busy && !susp_q && !done && wr_evt) |=> $stable(op_addr_q))
    else $error("command accepted while busy");
  a_lock_now: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_evt && pend_q == pnc_pkg::CMD_LOCK_SETUP &&
     wdata_q[7:0] == pnc_pkg::CMD_LOCK) |=> locked_q[blk_of(waddr_q)])
    else $error("lock not immediate");
  a_strobe_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_evt |-> $past(strobe_now) && !strobe_now)
    else $error("write taken without strobe release");
  a_reset_async: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> !sync_mode_o)
    else $error("sync mode after reset");
  c_prog: cover property (@(posedge clk_i) disable iff (!resetn_i)
    op_q == pnc_pkg::PNC_PROG ##1 op_q == pnc_pkg::PNC_IDLE);
  c_erase_susp: cover property (@(posedge clk_i) disable iff (!resetn_i)
    op_q == pnc_pkg::PNC_ERASE && susp_q);
  c_buf: cover property (@(posedge clk_i) disable iff (!resetn_i)
    op_q == pnc_pkg::PNC_BUFRUN);
endmodule : pnc_core

/* File: verification/pnc_host_model.sv */
`timescale 1ns/1ps
// ===========================================================
// host model: async bus cycles and the burst clock
module pnc_host_model (
  input  wire logic                       clk_i,
  input  wire logic [pnc_pkg::DATA_W-1:0] rd_data_i,
  input  wire logic                       rd_oe_i,
  output logic                            ce_n_o,
  output logic                            we_n_o,
  output logic                            oe_n_o,
  output logic                            adv_n_o,
  output logic      [pnc_pkg::ADDR_W-1:0] addr_o,
  output logic      [pnc_pkg::DATA_W-1:0] data_o,
  output logic                            link_clk_o
);
  logic run;

  // idle bus; burst clock parked low outside a frame
  initial begin
    {ce_n_o, we_n_o, oe_n_o, adv_n_o} = 4'he;
    addr_o = 8'h00;
    data_o = 16'h0000;
    run = 1'b0;
    link_clk_o = 1'b0;
    #7;
    forever begin
      #15;
      link_clk_o = run ? ~link_clk_o : 1'b0;
    end
  end

  // command cycle; held well past the pin synchroniser
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    data_o = d;
    ce_n_o = 1'b0;
    we_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    we_n_o = 1'b1;
    ce_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    data_o = ~d; // released bus must not look like the last word
    repeat (2) @(negedge clk_i);
  endtask : wr

  // async read; returns data word and output enable seen
  task automatic rd(input logic [7:0] a, output logic [15:0] q,
                    output logic oe);
    @(negedge clk_i);
    addr_o = a;
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    q = rd_data_i;
    oe = rd_oe_i;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
  endtask : rd

  // adv held low over three edges: two fill the mode synchroniser
  task automatic burst_open(input logic [7:0] a);
    @(negedge clk_i);
    addr_o = a;
    ce_n_o = 1'b0;
    run = 1'b1;
    repeat (3) @(posedge link_clk_o);
    @(negedge clk_i);
    adv_n_o = 1'b1;
  endtask : burst_open

  task automatic burst_close();
    @(negedge clk_i);
    run = 1'b0;
    ce_n_o = 1'b1;
    adv_n_o = 1'b0;
  endtask : burst_close
endmodule : pnc_host_model

/* File: verification/test_pnc_core.sv */
`timescale 1ns/1ps
// ===========================================================
// self-checking bench for the flash command interface
module test_pnc_core;
  logic        clk_i;
  logic        resetn_i;
  logic        supply_ok_i;
  logic        pw_match_i;
  logic        ce_n, we_n, oe_n, adv_n, link_clk;
  logic [7:0]  addr;
  logic [15:0] data, data_o, burst_data_o;
  logic        data_oe_o, wait_o, sync_mode_o, ready_o;
  int          fails;
  int          checks;

  pnc_core i_pnc_core (.clk_i(clk_i), .resetn_i(resetn_i),
    .link_clk_i(link_clk), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .adv_n_i(adv_n), .addr_i(addr), .data_i(data),
    .supply_ok_i(supply_ok_i), .pw_match_i(pw_match_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .burst_data_o(burst_data_o), .wait_o(wait_o),
    .sync_mode_o(sync_mode_o), .ready_o(ready_o));
  pnc_host_model i_pnc_host_model (.clk_i(clk_i), .rd_data_i(data_o),
    .rd_oe_i(data_oe_o), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n),
    .adv_n_o(adv_n), .addr_o(addr), .data_o(data), .link_clk_o(link_clk));

  // ===========================================================
  // clock, comparison and closing
  always #10 clk_i = ~clk_i;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  function automatic logic [15:0] cm(input logic [7:0] c);
    return {8'h00, c};
  endfunction : cm

  // ===========================================================
  // bus helpers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_pnc_host_model.wr(a, d);
  endtask : wr

  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(n < 1000), 16'h0001);
  endtask : wait_rdy

  // array read, always from read-array mode, sixteen bits wide
  task automatic arr(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic        oe;
    wr(a, cm(pnc_pkg::CMD_READ_ARRAY));
    i_pnc_host_model.rd(a, q, oe);
    check(q, exp);
    check(16'(oe), 16'h0001);
  endtask : arr

  task automatic st(input logic [15:0] exp);
    logic [15:0] q;
    logic        oe;
    wr(8'h00, cm(pnc_pkg::CMD_READ_STATUS));
    i_pnc_host_model.rd(8'h00, q, oe);
    check(q, exp);
  endtask : st

  task automatic prog(input logic [7:0] a, input logic [15:0] d);
    wr(a, cm(pnc_pkg::CMD_WORD_PROG));
    wr(a, d);
  endtask : prog

  task automatic erase(input logic [7:0] a);
    wr(a, cm(pnc_pkg::CMD_ERASE_SETUP));
    wr(a, cm(pnc_pkg::CMD_CONFIRM));
  endtask : erase

  // ===========================================================
  // scenarios
  task automatic t_reset();
    check(16'(ready_o), 16'h0001);
    check(16'(sync_mode_o), 16'h0000);
    check(16'(data_oe_o), 16'h0000);
  endtask : t_reset

  // one erase touches one block; busy ignores new work
  task automatic t_prog();
    erase(8'h40);
    wait_rdy();
    prog(8'h45, 16'h1234);
    check(16'(ready_o), 16'h0000);
    wait_rdy();
    st(16'h0080);
    erase(8'h00);
    prog(8'h46, 16'h0000);
    wait_rdy();
    arr(8'h46, 16'hffff);
    arr(8'h45, 16'h1234);
    arr(8'h05, 16'hffff);
  endtask : t_prog

  task automatic t_suspend();
    prog(8'h47, 16'h00ff);
    wr(8'h47, cm(pnc_pkg::CMD_SUSPEND));
    wait_rdy();
    st(16'h0084);
    arr(8'h45, 16'h1234);
    wr(8'h00, cm(pnc_pkg::CMD_CONFIRM));
    wait_rdy();
    arr(8'h47, 16'h00ff);
    erase(8'h00);
    wr(8'h00, cm(pnc_pkg::CMD_SUSPEND));
    wait_rdy();
    st(16'h00c0);
    arr(8'h45, 16'h1234);
    wr(8'h00, cm(pnc_pkg::CMD_CONFIRM));
    wait_rdy();
    arr(8'h05, 16'hffff);
  endtask : t_suspend

  task automatic t_buffer();
    wr(8'h48, cm(pnc_pkg::CMD_BUF_PROG));
    wr(8'h48, 16'h0003);
    for (int i = 0; i < 4; i++) wr(8'h48 + 8'(i), 16'h0a00 + 16'(i));
    wr(8'h48, cm(pnc_pkg::CMD_CONFIRM));
    wait_rdy();
    for (int i = 0; i < 4; i++) arr(8'h48 + 8'(i), 16'h0a00 + 16'(i));
  endtask : t_buffer

  // low supply and locked block both refuse, array untouched
  task automatic t_protect();
    supply_ok_i = 1'b0;
    prog(8'h49, 16'h0000);
    wait_rdy();
    st(16'h0098);
    arr(8'h49, 16'h0a01);
    wr(8'h00, cm(pnc_pkg::CMD_CLR_STATUS));
    supply_ok_i = 1'b1;
    erase(8'h80);
    wait_rdy();
    wr(8'h80, cm(pnc_pkg::CMD_LOCK_SETUP));
    wr(8'h80, cm(pnc_pkg::CMD_LOCK));
    prog(8'h81, 16'h0000);
    wait_rdy();
    st(16'h0092);
    wr(8'h00, cm(pnc_pkg::CMD_CLR_STATUS));
    st(16'h0080);
    wr(8'h80, cm(pnc_pkg::CMD_LOCK_SETUP));
    wr(8'h80, cm(pnc_pkg::CMD_UNLOCK));
    prog(8'h81, 16'h5a5a);
    wait_rdy();
    arr(8'h81, 16'h5a5a);
  endtask : t_protect

  // burst of two words after configuration selects sync reads
  task automatic t_burst();
    int n;
    wr(8'h00, cm(pnc_pkg::CMD_LOCK_SETUP));
    wr(8'h00, cm(pnc_pkg::CMD_CFG_CONFIRM));
    check(16'(sync_mode_o), 16'h0001);
    i_pnc_host_model.burst_open(8'h45);
    @(negedge link_clk);
    check(16'(wait_o), 16'h0001);
    n = 0;
    while (wait_o !== 1'b0 && n < 8) begin
      @(negedge link_clk);
      n++;
    end
    check(burst_data_o, 16'h1234);
    @(negedge link_clk);
    check(burst_data_o, 16'hffff);
    i_pnc_host_model.burst_close();
  endtask : t_burst

  // reset in mid-erase stops it and returns to async reads
  task automatic t_reset_mid();
    erase(8'h80);
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(16'(ready_o), 16'h0001);
    check(16'(sync_mode_o), 16'h0000);
  endtask : t_reset_mid

  // ===========================================================
  // main sequence and watchdog
  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    supply_ok_i = 1'b1;
    pw_match_i = 1'b0;
    fails = 0;
    checks = 0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_prog();
    t_suspend();
    t_buffer();
    t_protect();
    t_burst();
    t_reset_mid();
    final_report();
  end

  // whole run is a few thousand cycles; far beyond that is a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    final_report();
  end
endmodule : test_pnc_core
